// *** rtl/mss_memory_select.sv ***
// Memory enable gating plus power-on and keyboard ROM test sequencing
//
// Functional notes
// R1: 2k byte RAM and 32k byte ROM space reachable from processor bus.
// R2: RAM enabled only while address strobe and RAM select both asserted.
// R3: Address strobe inverted to active low before memory enables.
// R4: Processor picks RAM read or write via its direction signal.
// R5: RAM location decoded from address lines 0 through 12.
// R6: RAM data sits directly on the eight bit processor data bus.
// R7: Each ROM enabled when inverted strobe low and own select low.
// R8: ROM1 uses address 0 to 14, ROM2 and ROM3 use 0 to 12.
// R9: ROM selects decoded from the top address lines 13 to 15.
// R10: Power-on RAM failure shows code 1000 on frequency display.
// R11: Power-on ROM1, ROM2, ROM3 failures show 0100, 0010, 0001.
// R12: Power-on error code held until any front-panel key pressed.
// R13: ROM test checks all; halts after pass on fail, else counts passes.
// R14: ROM test is menu item 5 and runs until user stops it.
// R15: ROM test malfunction shows code 50 on frequency display.
// R16: Menu item 7 confirmed exits tests, reinitialising as power-on.
// R17: At most one memory select asserted for any address.
`timescale 1ns/1ps
`include "mss_params.svh"

module mss_memory_select (
	input  wire logic                sys_clk,           // System clock, 125 MHz
	input  wire logic                rst_n,             // Synchronous reset, low
	input  wire logic [15:0]         addr,              // Processor address bus
	input  wire logic                valid_address_strobe, // Valid address, high
	input  wire logic                rw_dir,            // Processor direction, 1 read
	input  wire logic [7:0]          cpu_dout,          // Processor write data
	input  wire logic [7:0]          ram_rdata,         // RAM read data
	input  wire logic [7:0]          rom_rdata,         // Selected ROM read data
	output logic [7:0]               cpu_din,           // Data to processor
	output mss_pkg::mss_enables_t    enables,           // Active low chip enables
	output logic [12:0]              ram_addr,          // RAM location
	output logic [14:0]              rom_addr,          // ROM location
	output logic                     ram_we_n,          // RAM write, low
	output logic [7:0]               ram_wdata,         // RAM write data
	input  wire logic                post_start,        // Power-on check begin pulse
	input  wire logic                post_done,         // Check finished pulse
	input  wire logic [3:0]          post_fail,         // RAM,ROM1,ROM2,ROM3 failed
	input  wire logic                key_any,           // Any panel key pulse
	input  wire logic                test_enter,        // Enter test menu pulse
	input  wire logic                menu_step,         // Next menu item pulse
	input  wire logic                step_confirm_key,  // Confirm pulse
	input  wire logic                romtest_pass_done, // ROM checksum pass finished
	input  wire logic                romtest_fail,      // That pass found a fault
	output logic                     romtest_run,       // ROM test sweep active
	output logic                     reinit,            // Reinitialise pulse
	output logic [15:0]              freq_code,         // Frequency display code
	output logic [15:0]              pass_count,        // Amplitude display count
	output logic [3:0]               menu_item          // Modulation display item
);

	////////////////////////////////////////////////////////////////////////
	// Address decode
	logic        valid_address_strobe_n;
	logic [2:0]  top_bits;
	logic        sel_ram_n;
	logic        sel_rom1_n;
	logic        sel_rom2_n;
	logic        sel_rom3_n;
	mss_pkg::mss_state_t state_reg;
	mss_pkg::mss_state_t state_next;

	// One hot-low select from top bits
	function automatic logic [3:0] decode_top(input logic [2:0] t);
		logic [3:0] s;
		s = 4'hF;
		case (t)
			`MSS_SEL_RAM:    s = 4'h7;
			`MSS_SEL_ROM1_A: s = 4'hB;
			`MSS_SEL_ROM1_B: s = 4'hB;
			`MSS_SEL_ROM1_C: s = 4'hB;
			`MSS_SEL_ROM1_D: s = 4'hB;
			`MSS_SEL_ROM2:   s = 4'hD;
			`MSS_SEL_ROM3:   s = 4'hE;
			default:         s = 4'hF;
		endcase
		return s;
	endfunction

	// R9: top address decode
	assign top_bits = addr[15:`MSS_DEC_LSB];
	// R17: decoder yields one select at most
	assign {sel_ram_n, sel_rom1_n, sel_rom2_n, sel_rom3_n} = decode_top(top_bits);
	// R3: strobe inverted
	assign valid_address_strobe_n = ~valid_address_strobe;

	////////////////////////////////////////////////////////////////////////
	// Chip enables, combinational so the bus timing matches the parts
	// R2: RAM enable gating
	assign enables.ram_ce_n  = valid_address_strobe_n | sel_ram_n;
	// R7: ROM enable gating
	assign enables.rom1_ce_n = valid_address_strobe_n | sel_rom1_n;
	assign enables.rom2_ce_n = valid_address_strobe_n | sel_rom2_n;
	assign enables.rom3_ce_n = valid_address_strobe_n | sel_rom3_n;
	// R5: RAM location lines
	assign ram_addr = addr[`MSS_RAM_ADDR_MSB:0];
	// R8: ROM1 wide, ROM2 and ROM3 narrow
	assign rom_addr = (!sel_rom1_n) ? addr[`MSS_ROM1_ADDR_MSB:0]
		: {2'h0, addr[`MSS_ROM23_ADDR_MSB:0]};
	// R4: direction from processor; R6: straight data path
	assign ram_we_n  = enables.ram_ce_n | rw_dir;
	assign ram_wdata = cpu_dout;

	// R1: read data from whichever store is enabled
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			cpu_din <= 8'h00;
		end else if (!enables.ram_ce_n && rw_dir) begin
			cpu_din <= ram_rdata;
		end else if (!(enables.rom1_ce_n & enables.rom2_ce_n & enables.rom3_ce_n)) begin
			cpu_din <= rom_rdata;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Test sequencer
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			mss_pkg::ST_IDLE: begin
				if (post_start) begin
					state_next = mss_pkg::ST_POST;
				end else if (test_enter) begin
					state_next = mss_pkg::ST_MENU;
				end
			end
			mss_pkg::ST_POST: begin
				if (post_done) begin
					state_next = (post_fail != 4'h0) ? mss_pkg::ST_SHOWERR
						: mss_pkg::ST_IDLE;
				end
			end
			mss_pkg::ST_SHOWERR: begin
				if (key_any) begin
					state_next = mss_pkg::ST_IDLE;
				end
			end
			mss_pkg::ST_MENU: begin
				if (step_confirm_key && menu_item == `MSS_TEST_ROM) begin
					state_next = mss_pkg::ST_ROMRUN;
				end else if (step_confirm_key && menu_item == `MSS_TEST_EXIT) begin
					state_next = mss_pkg::ST_POST;
				end
			end
			mss_pkg::ST_ROMRUN: begin
				if (menu_step) begin
					state_next = mss_pkg::ST_MENU;
				end else if (romtest_pass_done && romtest_fail) begin
					state_next = mss_pkg::ST_ROMHALT;
				end
			end
			mss_pkg::ST_ROMHALT: begin
				if (menu_step) begin
					state_next = mss_pkg::ST_MENU;
				end
			end
			default: state_next = mss_pkg::ST_IDLE;
		endcase
	end

	// State register; power-on check follows reset via post_start
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			state_reg <= mss_pkg::ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// R16: exit reinitialises as power-on
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			reinit <= 1'b0;
		end else begin
			reinit <= (state_reg == mss_pkg::ST_MENU) && step_confirm_key
				&& (menu_item == `MSS_TEST_EXIT);
		end
	end

	// R14: menu item stepping, wraps past exit item
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			menu_item <= 4'h1;
		end else if (state_reg == mss_pkg::ST_MENU && menu_step) begin
			menu_item <= (menu_item == `MSS_TEST_EXIT) ? 4'h1 : menu_item + 4'h1;
		end else if (state_reg == mss_pkg::ST_IDLE && test_enter) begin
			menu_item <= 4'h1;
		end
	end

	// R13: pass counter advances only on clean passes
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			pass_count <= 16'h0000;
		end else if (state_reg == mss_pkg::ST_MENU && step_confirm_key
			&& menu_item == `MSS_TEST_ROM) begin
			pass_count <= 16'h0000;
		end else if (state_reg == mss_pkg::ST_ROMRUN && romtest_pass_done
			&& !romtest_fail && !menu_step) begin
			pass_count <= pass_count + 16'h0001;
		end
	end

	// R10: R11: R12: R15: display code priority RAM first
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			freq_code <= `MSS_CODE_NONE;
		end else if (state_reg == mss_pkg::ST_POST && post_done) begin
			if (post_fail[3]) begin
				freq_code <= `MSS_CODE_RAM;
			end else if (post_fail[2]) begin
				freq_code <= `MSS_CODE_ROM1;
			end else if (post_fail[1]) begin
				freq_code <= `MSS_CODE_ROM2;
			end else if (post_fail[0]) begin
				freq_code <= `MSS_CODE_ROM3;
			end else begin
				freq_code <= `MSS_CODE_NONE;
			end
		end else if (state_reg == mss_pkg::ST_SHOWERR && key_any) begin
			freq_code <= `MSS_CODE_NONE;
		end else if (state_reg == mss_pkg::ST_ROMRUN && romtest_pass_done
			&& romtest_fail && !menu_step) begin
			freq_code <= `MSS_CODE_ROMTEST;
		end
	end

	assign romtest_run = (state_reg == mss_pkg::ST_ROMRUN);

	////////////////////////////////////////////////////////////////////////
	// Assertions
	property p_ram_gate;
		@(posedge sys_clk) disable iff (!rst_n)
		!enables.ram_ce_n |-> (valid_address_strobe && addr[15:13] == 3'h7);
	endproperty
	a_ram_gate: assert property (p_ram_gate) else $error("RAM enable without cause"); // R2

	property p_rom_gate;
		@(posedge sys_clk) disable iff (!rst_n)
		!valid_address_strobe |-> (enables.rom1_ce_n && enables.rom2_ce_n
			&& enables.rom3_ce_n && enables.ram_ce_n);
	endproperty
	a_rom_gate: assert property (p_rom_gate) else $error("Enable without strobe"); // R7

	property p_one_sel;
		@(posedge sys_clk) disable iff (!rst_n)
		$onehot0(~enables);
	endproperty
	a_one_sel: assert property (p_one_sel) else $error("Several enables active"); // R17

	property p_rom2_dec;
		@(posedge sys_clk) disable iff (!rst_n)
		(valid_address_strobe && addr[15:13] == 3'h4) |-> !enables.rom2_ce_n;
	endproperty
	a_rom2_dec: assert property (p_rom2_dec) else $error("ROM2 decode wrong"); // R9

	property p_ram_code;
		@(posedge sys_clk) disable iff (!rst_n)
		(state_reg == mss_pkg::ST_POST && post_done && post_fail[3])
			|=> freq_code == 16'h1000;
	endproperty
	a_ram_code: assert property (p_ram_code) else $error("RAM code wrong"); // R10

	property p_rom3_code;
		@(posedge sys_clk) disable iff (!rst_n)
		(state_reg == mss_pkg::ST_POST && post_done && post_fail == 4'h1)
			|=> freq_code == 16'h0001;
	endproperty
	a_rom3_code: assert property (p_rom3_code) else $error("ROM3 code wrong"); // R11

	property p_hold_err;
		@(posedge sys_clk) disable iff (!rst_n)
		(state_reg == mss_pkg::ST_SHOWERR && !key_any) |=> $stable(freq_code);
	endproperty
	a_hold_err: assert property (p_hold_err) else $error("Error code lost"); // R12

	sequence s_clean_pass;
		state_reg == mss_pkg::ST_ROMRUN && romtest_pass_done && !romtest_fail && !menu_step;
	endsequence
	property p_pass_inc;
		@(posedge sys_clk) disable iff (!rst_n)
		s_clean_pass |=> pass_count == $past(pass_count) + 16'h0001;
	endproperty
	a_pass_inc: assert property (p_pass_inc) else $error("Pass count not advanced"); // R13

	property p_fail50;
		@(posedge sys_clk) disable iff (!rst_n)
		(romtest_run && romtest_pass_done && romtest_fail && !menu_step)
			|=> (freq_code == 16'h0050 && state_reg == mss_pkg::ST_ROMHALT);
	endproperty
	a_fail50: assert property (p_fail50) else $error("ROM fault not shown"); // R15

	property p_exit;
		@(posedge sys_clk) disable iff (!rst_n)
		(state_reg == mss_pkg::ST_MENU && step_confirm_key && menu_item == 4'h7)
			|=> (reinit && state_reg == mss_pkg::ST_POST);
	endproperty
	a_exit: assert property (p_exit) else $error("Exit did not reinitialise"); // R16

endmodule

// *** rtl/mss_params.svh ***
// Constants for the memory select and self test block
`ifndef MSS_PARAMS_SVH
`define MSS_PARAMS_SVH
`define MSS_RAM_BYTES      2048
`define MSS_ROM_BYTES      32768
`define MSS_RAM_ADDR_MSB   12
`define MSS_ROM1_ADDR_MSB  14
`define MSS_ROM23_ADDR_MSB 12
`define MSS_DEC_LSB        13
`define MSS_SEL_RAM        3'h7
`define MSS_SEL_ROM1_A     3'h0
`define MSS_SEL_ROM1_B     3'h1
`define MSS_SEL_ROM1_C     3'h2
`define MSS_SEL_ROM1_D     3'h3
`define MSS_SEL_ROM2       3'h4
`define MSS_SEL_ROM3       3'h5
`define MSS_CODE_RAM       16'h1000
`define MSS_CODE_ROM1      16'h0100
`define MSS_CODE_ROM2      16'h0010
`define MSS_CODE_ROM3      16'h0001
`define MSS_CODE_NONE      16'h0000
`define MSS_CODE_ROMTEST   16'h0050
`define MSS_TEST_ROM       4'h5
`define MSS_TEST_EXIT      4'h7
`endif

// *** rtl/mss_pkg.sv ***
// Types for the memory select and self test block
package mss_pkg;
	typedef struct packed {
		logic ram_ce_n;
		logic rom1_ce_n;
		logic rom2_ce_n;
		logic rom3_ce_n;
	} mss_enables_t;
	typedef enum logic [2:0] {
		ST_IDLE    = 3'b000,
		ST_POST    = 3'b001,
		ST_SHOWERR = 3'b010,
		ST_MENU    = 3'b011,
		ST_ROMRUN  = 3'b100,
		ST_ROMHALT = 3'b101
	} mss_state_t;
endpackage

// *** test/mss_mem_model.sv ***
// Memory parts model answering the block's enables and addresses
`timescale 1ns/1ps
module mss_mem_model (
	input  wire logic                 sys_clk,   // System clock
	input  wire mss_pkg::mss_enables_t enables,  // Active low chip enables
	input  wire logic [12:0]          ram_addr,  // RAM location
	input  wire logic [14:0]          rom_addr,  // ROM location
	input  wire logic                 ram_we_n,  // RAM write, low
	output logic [7:0]                ram_rdata, // RAM read data
	output logic [7:0]                rom_rdata  // ROM read data
);
	logic churn_reg = 1'b0;
	// Toggling filler so an unselected part never looks valid; one writer only
	always @(posedge sys_clk) begin
		churn_reg <= ~churn_reg;
	end
	// RAM drives only on enabled reads
	always_comb begin
		ram_rdata = {8{churn_reg}};
		if (!enables.ram_ce_n && ram_we_n) begin
			ram_rdata = ram_addr[7:0] ^ 8'h5A;
		end
	end
	// Any enabled ROM answers from its address
	always_comb begin
		rom_rdata = {8{~churn_reg}};
		if (!(enables.rom1_ce_n && enables.rom2_ce_n && enables.rom3_ce_n)) begin
			rom_rdata = rom_addr[7:0] ^ 8'hA5;
		end
	end
endmodule

// *** test/mss_memory_select_tb_top.sv ***
// Self-checking bench for the memory select and self test block
`timescale 1ns/1ps
module mss_memory_select_tb_top;
	logic        sys_clk = 1'b0, rst_n = 1'b0, strobe = 1'b0, rw_dir = 1'b1, rt_fail = 1'b0;
	logic [15:0] addr = 16'h0000;
	logic [3:0]  post_fail = 4'h0;
	logic [6:0]  pv = 7'h00;
	logic [7:0]  wr_data = 8'h3C;
	logic [7:0]  cpu_din, ram_wdata, ram_rdata, rom_rdata;
	logic [12:0] ram_addr;
	logic [14:0] rom_addr;
	logic        ram_we_n, romtest_run, reinit;
	logic [15:0] freq_code, pass_count;
	logic [3:0]  menu_item;
	mss_pkg::mss_enables_t en;
	int          fail_count = 0;
	int          compares = 0;
	always #4 sys_clk = ~sys_clk;
	mss_memory_select u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .addr(addr),
		.valid_address_strobe(strobe), .rw_dir(rw_dir), .cpu_dout(wr_data),
		.ram_rdata(ram_rdata), .rom_rdata(rom_rdata), .cpu_din(cpu_din), .enables(en),
		.ram_addr(ram_addr), .rom_addr(rom_addr), .ram_we_n(ram_we_n),
		.ram_wdata(ram_wdata), .post_start(pv[0]), .post_done(pv[1]),
		.post_fail(post_fail), .key_any(pv[2]), .test_enter(pv[3]), .menu_step(pv[4]),
		.step_confirm_key(pv[5]), .romtest_pass_done(pv[6]), .romtest_fail(rt_fail),
		.romtest_run(romtest_run), .reinit(reinit), .freq_code(freq_code),
		.pass_count(pass_count), .menu_item(menu_item));
	mss_mem_model u_mem (.sys_clk(sys_clk), .enables(en), .ram_addr(ram_addr),
		.rom_addr(rom_addr), .ram_we_n(ram_we_n), .ram_rdata(ram_rdata),
		.rom_rdata(rom_rdata));
	////////////////////////////////////////////////////////////////////////
	// Shared compare, counted
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: %s", $time, msg);
		end
	endtask
	// One-cycle pulse; outputs have settled on return
	task automatic pulse(input int b);
		@(posedge sys_clk) pv[b] <= 1'b1;
		@(posedge sys_clk) pv[b] <= 1'b0;
		#1;
	endtask
	task automatic print_verdict();
		$display("compares=%0d fail_count=%0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	// Every top-bits region, read checked in all but unmapped region 6, then RAM write, then strobe low
	task automatic bus_decode();
		logic [15:0] a;
		logic [3:0]  e;
		for (int k = 0; k < 8; k++) begin
			a = {k[2:0], 13'h1ABC};
			e = {k != 7, k > 3, k != 4, k != 5};
			@(posedge sys_clk) addr <= a;
			strobe <= 1'b1;
			rw_dir <= 1'b1;
			#1;
			chk({12'h000, en}, {12'h000, e}, "enables");
			chk({3'h0, ram_addr}, {3'h0, a[12:0]}, "ram address");
			chk({1'b0, rom_addr}, (k < 4) ? {1'b0, a[14:0]} : {3'h0, a[12:0]}, "rom addr");
			@(posedge sys_clk) #1;
			if (k != 6) chk({8'h00, cpu_din}, {8'h00, a[7:0] ^ ((k == 7) ? 8'h5A : 8'hA5)}, "rd");
		end
		@(posedge sys_clk) rw_dir <= 1'b0;
		wr_data <= 8'hC3;
		#1;
		chk({15'h0, ram_we_n}, 16'h0000, "ram write strobe");
		chk({8'h00, ram_wdata}, 16'h00C3, "ram write data");
		@(posedge sys_clk) strobe <= 1'b0;
		#1;
		chk({12'h000, en}, 16'h000F, "enables with strobe low");
		chk({15'h0, ram_we_n}, 16'h0001, "no write with strobe low");
	endtask
	// Power-on check codes, priority and hold until a key
	task automatic post_codes();
		logic [3:0]  f[5] = '{4'h8, 4'h4, 4'h2, 4'h1, 4'hC};
		logic [15:0] c[5] = '{16'h1000, 16'h0100, 16'h0010, 16'h0001, 16'h1000};
		for (int i = 0; i < 5; i++) begin
			pulse(0);
			@(posedge sys_clk) post_fail <= f[i];
			pulse(1);
			chk(freq_code, c[i], "power-on code");
			repeat (3) @(posedge sys_clk);
			#1;
			chk(freq_code, c[i], "code held");
			pulse(2);
			chk(freq_code, 16'h0000, "code cleared by key");
		end
		@(posedge sys_clk) post_fail <= 4'h0;
	endtask
	// Menu item 5 runs, counts, halts on fault; item 7 reinitialises
	task automatic rom_test();
		logic r1;
		pulse(3);
		chk({12'h000, menu_item}, 16'h0001, "menu start");
		repeat (4) pulse(4);
		chk({12'h000, menu_item}, 16'h0005, "menu item five");
		pulse(5);
		chk({15'h0, romtest_run}, 16'h0001, "rom test running");
		chk(pass_count, 16'h0000, "count cleared");
		pulse(6);
		pulse(6);
		chk(pass_count, 16'h0002, "two passes");
		@(posedge sys_clk) rt_fail <= 1'b1;
		pulse(6);
		chk(freq_code, 16'h0050, "rom fault code");
		chk({15'h0, romtest_run}, 16'h0000, "halted");
		pulse(6);
		chk(pass_count, 16'h0002, "no count when halted");
		@(posedge sys_clk) rt_fail <= 1'b0;
		pulse(4);
		for (int n = 0; n < 8 && menu_item !== 4'h7; n++) pulse(4);
		chk({12'h000, menu_item}, 16'h0007, "menu item seven");
		pulse(4);
		chk({12'h000, menu_item}, 16'h0001, "menu wraps past seven");
		for (int n = 0; n < 8 && menu_item !== 4'h7; n++) pulse(4);
		chk({12'h000, menu_item}, 16'h0007, "menu item seven again");
		pulse(5);
		r1 = reinit;
		@(posedge sys_clk) #1;
		chk({15'h0, r1 ^ reinit}, 16'h0001, "one reinit pulse");
		pulse(1);
		chk(freq_code, 16'h0000, "clean restart");
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (6) @(posedge sys_clk);
		rst_n <= 1'b1;
		bus_decode();
		post_codes();
		rom_test();
		print_verdict();
	end
	// Watchdog well beyond the roughly 120 cycles needed
	initial begin
		#100000;
		fail_count++;
		print_verdict();
	end
endmodule
